/* bench/pieb_chk.sv */
`timescale 1ns/10ps
// ------------------------------
// Bus and request checks
// ------------------------------
module pieb_chk (
  input wire        clk_i,
  input wire        rst_i,
  input wire        cyc_i,
  input wire        stb_i,
  input wire [31:0] dat_o,
  input wire        ack_o,
  input wire        global_irq_enable_i,
  input wire        periph_master_enable_i,
  input wire        periph_irq_req_o,
  input wire        core_irq_req_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_ack;
    ack_o ##1 !ack_o;
  endsequence
  chk_ack_one_cycle: assert property (s_req |=> s_ack) else $error("ack not one cycle wide after request");
  chk_ack_has_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
  chk_read_upper_zero: assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("upper data not zero");
  chk_data_idle_zero: assert property (!ack_o |-> dat_o == 32'h0) else $error("data not zero when idle");
  chk_periph_gate: assert property (!$past(periph_master_enable_i) |-> !periph_irq_req_o)
    else $error("peripheral request without master enable");
  chk_core_gate: assert property (!$past(global_irq_enable_i) |-> !core_irq_req_o)
    else $error("core request without global enable");
  chk_core_pairs: assert property (core_irq_req_o && $past(periph_master_enable_i) |-> periph_irq_req_o)
    else $error("core request without peripheral term");
  chk_periph_pairs: assert property (periph_irq_req_o && $past(global_irq_enable_i) |-> core_irq_req_o)
    else $error("peripheral term not passed to core");
endmodule

bind pieb_bank pieb_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o),
  .ack_o(ack_o), .global_irq_enable_i(global_irq_enable_i), .periph_master_enable_i(periph_master_enable_i),
  .periph_irq_req_o(periph_irq_req_o), .core_irq_req_o(core_irq_req_o));

/* bench/pieb_src.sv */
`timescale 1ns/10ps
// ------------------------------
// Event sources and core enables
// ------------------------------
module pieb_src (
  input  wire       clk_i,
  output reg  [3:0] evt_o,
  output reg  [3:0] flag_o,
  output reg        glb_en_o,
  output reg        per_en_o
);
  initial begin
    evt_o = 4'h0;
    flag_o = 4'h0;
    glb_en_o = 1'b0;
    per_en_o = 1'b0;
  end
  // One-cycle pulse, as a same-clock peripheral event
  task pulse(input [3:0] m);
    begin
      @(posedge clk_i);
      evt_o <= m;
      @(posedge clk_i);
      evt_o <= 4'h0;
    end
  endtask
endmodule

/* bench/tb.sv */
`timescale 1ns/10ps
`include "pieb_map.vh"
module tb;
  reg         clk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg  [7:0]  adr_i = 8'h00;
  reg  [31:0] dat_i = 32'h0;
  reg  [3:0]  sel_i = 4'hF;
  reg         we_i = 1'b0;
  reg         cyc_i = 1'b0;
  reg         stb_i = 1'b0;
  wire [31:0] dat_o;
  wire        ack_o;
  wire        periph_irq_req_o;
  wire        core_irq_req_o;
  wire        irq_o;
  wire [3:0]  evt;
  wire [3:0]  flg;
  wire        glb_en;
  wire        per_en;
  integer     fails = 0;
  integer     tests_run = 0;
  integer     cycles = 0;
  integer     i;
  reg  [31:0] rd;
  reg  [7:0]  a;
  reg  [7:0]  eb;
  always #10 clk_i = ~clk_i;
  pieb_src u_src (.clk_i(clk_i), .evt_o(evt), .flag_o(flg), .glb_en_o(glb_en), .per_en_o(per_en));
  pieb_bank u_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .timer1_gate_evt_i(evt[3]),
    .converter_evt_i(evt[2]), .timer2_match_evt_i(evt[1]), .timer1_overflow_evt_i(evt[0]),
    .comparator_one_irq_flag_i(flg[3]), .num_osc_irq_flag_i(flg[2]), .logic_cell_two_irq_flag_i(flg[1]),
    .logic_cell_one_irq_flag_i(flg[0]), .global_irq_enable_i(glb_en), .periph_master_enable_i(per_en),
    .periph_irq_req_o(periph_irq_req_o), .core_irq_req_o(core_irq_req_o), .irq_o(irq_o));
  // ------------------------------
  // Bus, compare and verdict tasks
  // ------------------------------
  task print_verdict;
    begin
      if (fails == 0 && tests_run > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task chk(input [8*6-1:0] what, input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("[FAIL] %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  // Leaves one idle cycle so the slave never sees a held request
  task wb(input w, input [7:0] ad, input [7:0] d);
    begin
      adr_i <= ad;
      dat_i <= {24'h0, d};
      we_i <= w;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      @(posedge clk_i);
      while (ack_o !== 1'b1)
        @(posedge clk_i);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  task settle;
    repeat (4) @(posedge clk_i);
  endtask
  function [31:0] exp_rd(input [7:0] ad);
    case (ad)
      `PIEB_OFF_ENABLE_1, `PIEB_OFF_REQUEST_1, `PIEB_OFF_PENDING: exp_rd = {24'h0, `PIEB_IMPL_1};
      `PIEB_OFF_ENABLE_2: exp_rd = {24'h0, `PIEB_IMPL_2};
      `PIEB_OFF_ENABLE_3: exp_rd = {24'h0, `PIEB_IMPL_3};
      `PIEB_OFF_IRQ_MASK: exp_rd = {24'h0, `PIEB_IMPL_STATUS};
      default: exp_rd = 32'h0;
    endcase
  endfunction
  function [7:0] src_bit(input [2:0] n);
    case (n)
      3'h0, 3'h4: src_bit = 8'h01;
      3'h1, 3'h5: src_bit = 8'h02;
      3'h2: src_bit = 8'h40;
      3'h3: src_bit = 8'h80;
      3'h6: src_bit = 8'h04;
      default: src_bit = 8'h20;
    endcase
  endfunction
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails = fails + 1;
      print_verdict;
    end
  end
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (a = 8'h00; a < 8'h24; a = a + 8'h04) begin
      wb(1'b0, a, 8'h00);
      chk("reset", rd, 32'h0);
    end
    for (a = 8'h00; a < 8'h24; a = a + 8'h04) begin
      wb(1'b1, a, 8'hFF);
      wb(1'b0, a, 8'h00);
      chk("impl", rd, exp_rd(a));
    end
    for (a = 8'h00; a < 8'h24; a = a + 8'h04)
      wb(1'b1, a, 8'h00);
    wb(1'b0, `PIEB_OFF_REQUEST_1, 8'h00);
    chk("wclr", rd, 32'h0);
    sel_i <= 4'hE;
    wb(1'b1, `PIEB_OFF_ENABLE_1, 8'hFF);
    sel_i <= 4'hF;
    wb(1'b0, `PIEB_OFF_ENABLE_1, 8'h00);
    chk("sel", rd, 32'h0);
    u_src.per_en_o <= 1'b1;
    u_src.glb_en_o <= 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      u_src.pulse(4'h1 << i);
      wb(1'b0, `PIEB_OFF_REQUEST_1, 8'h00);
      chk("flag", rd, {i == 3, i == 2, 4'h0, i == 1, i == 0});
      chk("noen", periph_irq_req_o, 32'h0);
      wb(1'b1, `PIEB_OFF_REQUEST_1, 8'h00);
    end
    wb(1'b1, `PIEB_OFF_IRQ_MASK, 8'h01);
    for (i = 0; i < 8; i = i + 1) begin
      a = (i < 4) ? `PIEB_OFF_ENABLE_1 : ((i < 6) ? `PIEB_OFF_ENABLE_3 : `PIEB_OFF_ENABLE_2);
      eb = src_bit(i[2:0]);
      if (i == 7)
        wb(1'b1, `PIEB_OFF_IRQ_MASK, 8'h00);
      if (i < 4)
        u_src.pulse(4'h1 << i);
      else
        u_src.flag_o <= 4'h1 << (i - 4);
      wb(1'b1, a, ~eb);
      wb(1'b1, `PIEB_OFF_IRQ_STATUS, 8'h03);
      settle;
      chk("other", periph_irq_req_o, 32'h0);
      wb(1'b1, a, eb);
      settle;
      chk("preq", periph_irq_req_o, 32'h1);
      chk("creq", core_irq_req_o, 32'h1);
      chk("irq", irq_o, {31'h0, i != 7});
      wb(1'b0, `PIEB_OFF_PENDING, 8'h00);
      chk("pend", rd, 32'h1 << ((i < 2) ? i : ((i < 4) ? i + 4 : i - 2)));
      wb(1'b0, `PIEB_OFF_CORE_VIEW, 8'h00);
      chk("view", rd, 32'h0000_00C3);
      wb(1'b0, `PIEB_OFF_IRQ_STATUS, 8'h00);
      chk("stat", rd, 32'h3);
      wb(1'b1, `PIEB_OFF_IRQ_STATUS, 8'h03);
      settle;
      chk("irqclr", irq_o, 32'h0);
      u_src.per_en_o <= 1'b0;
      settle;
      chk("pgate", periph_irq_req_o, 32'h0);
      u_src.per_en_o <= 1'b1;
      u_src.glb_en_o <= 1'b0;
      settle;
      chk("ggate", core_irq_req_o, 32'h0);
      chk("pkeep", periph_irq_req_o, 32'h1);
      u_src.glb_en_o <= 1'b1;
      u_src.flag_o <= 4'h0;
      wb(1'b1, `PIEB_OFF_REQUEST_1, 8'h00);
      wb(1'b1, a, 8'h00);
    end
    // Second reset in mid-run must clear the registers at 0x00 to 0x14, irq_o and the peripheral request again
    wb(1'b1, `PIEB_OFF_ENABLE_1, 8'hFF);
    wb(1'b1, `PIEB_OFF_REQUEST_1, 8'hFF);
    wb(1'b1, `PIEB_OFF_IRQ_MASK, 8'h03);
    settle;
    chk("prst", irq_o, 32'h1);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("rirq", irq_o, 32'h0);
    for (a = 8'h00; a < 8'h18; a = a + 8'h04) begin
      wb(1'b0, a, 8'h00);
      chk("rst2", rd, 32'h0);
    end
    chk("rpreq", periph_irq_req_o, 32'h0);
    print_verdict;
  end
endmodule

/* rtl/pieb_bank.v */
// Design decisions made here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "pieb_map.vh"

// ----------------------------------------
// Behaviour notes
// ----------------------------------------
// One wait state per access; unmapped offsets still answer
// with zero data, so a stray access never hangs the bus.
// Only byte lane 0 carries data; other lanes are ignored.
// Writing one to a flag raises it, handy as a test hook.
// Flags set whatever the enables hold; clearing a stale flag
// before enabling its source is left to software.
// Requests trail the flags by one cycle, the price of
// outputs taken straight from flip-flops.
// Core view shows the master enables live, not latched.
// Mask never clears status; masked bits stay visible.

module pieb_bank (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire [7:0]  adr_i,
  input  wire [31:0] dat_i,
  input  wire [3:0]  sel_i,
  input  wire        we_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  output wire [31:0] dat_o,
  output wire        ack_o,
  // Peripheral event pulses
  input  wire        timer1_gate_evt_i,
  input  wire        converter_evt_i,
  input  wire        timer2_match_evt_i,
  input  wire        timer1_overflow_evt_i,
  // Flags held in other request registers
  input  wire        comparator_one_irq_flag_i,
  input  wire        num_osc_irq_flag_i,
  input  wire        logic_cell_two_irq_flag_i,
  input  wire        logic_cell_one_irq_flag_i,
  // Core master enables
  input  wire        global_irq_enable_i,
  input  wire        periph_master_enable_i,
  // Requests
  output wire        periph_irq_req_o,
  output wire        core_irq_req_o,
  output wire        irq_o
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Word decode: low two address bits ignored
  function hit;
    input [7:0] addr;
    input [7:0] offset;
    begin
      hit = (addr[7:2] == offset[7:2]);
    end
  endfunction

  // Implemented bits only; others stay zero
  function [7:0] keep_impl;
    input [7:0] value;
    input [7:0] impl;
    begin
      keep_impl = value & impl;
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg  [7:0]  enable_1_q;
  reg  [7:0]  enable_1_d;
  reg  [7:0]  enable_2_q;
  reg  [7:0]  enable_2_d;
  reg  [7:0]  enable_3_q;
  reg  [7:0]  enable_3_d;
  reg  [7:0]  request_1_q;
  reg  [7:0]  request_1_d;
  reg  [7:0]  status_q;
  reg  [7:0]  status_d;
  reg  [7:0]  mask_q;
  reg  [7:0]  mask_d;
  reg         ack_q;
  reg         ack_d;
  reg  [31:0] rdata_q;
  reg  [31:0] rdata_d;
  reg         preq_q;
  reg         preq_d;
  reg         creq_q;
  reg         creq_d;
  reg         irq_q;
  reg         irq_d;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire        access;
  wire        take;
  wire        rd_take;
  wire        wr_commit;
  wire [7:0]  wbyte;
  wire        wr_en_1;
  wire        wr_en_2;
  wire        wr_en_3;
  wire        wr_req_1;
  wire        wr_status;
  wire        wr_mask;

  assign access    = cyc_i & stb_i;
  // New request, not yet answered
  assign take      = access & ~ack_q;
  assign rd_take   = take & ~we_i;
  // Write lands on the edge where the master sees ack
  assign wr_commit = access & we_i & ack_q & sel_i[0];
  assign wbyte     = dat_i[7:0];
  assign wr_en_1   = wr_commit & hit(adr_i, `PIEB_OFF_ENABLE_1);
  assign wr_en_2   = wr_commit & hit(adr_i, `PIEB_OFF_ENABLE_2);
  assign wr_en_3   = wr_commit & hit(adr_i, `PIEB_OFF_ENABLE_3);
  assign wr_req_1  = wr_commit & hit(adr_i, `PIEB_OFF_REQUEST_1);
  assign wr_status = wr_commit & hit(adr_i, `PIEB_OFF_IRQ_STATUS);
  assign wr_mask   = wr_commit & hit(adr_i, `PIEB_OFF_IRQ_MASK);

  // ----------------------------------------
  // Source gating
  // ----------------------------------------
  wire        gate_timer1_gate;
  wire        gate_converter;
  wire        gate_timer2;
  wire        gate_timer1_ovf;
  wire        gate_comp_one;
  wire        gate_num_osc;
  wire        gate_cell_two;
  wire        gate_cell_one;
  wire [7:0]  pending;
  reg  [7:0]  event_set;
  reg  [7:0]  core_view;

  assign gate_timer1_gate = request_1_q[`PIEB_BIT_TIMER1_GATE]
                          & enable_1_q[`PIEB_BIT_TIMER1_GATE];
  assign gate_converter   = request_1_q[`PIEB_BIT_CONVERTER]
                          & enable_1_q[`PIEB_BIT_CONVERTER];
  assign gate_timer2      = request_1_q[`PIEB_BIT_TIMER2]
                          & enable_1_q[`PIEB_BIT_TIMER2];
  assign gate_timer1_ovf  = request_1_q[`PIEB_BIT_TIMER1_OVF]
                          & enable_1_q[`PIEB_BIT_TIMER1_OVF];
  assign gate_comp_one    = comparator_one_irq_flag_i
                          & enable_2_q[`PIEB_BIT_COMP_ONE];
  assign gate_num_osc     = num_osc_irq_flag_i
                          & enable_2_q[`PIEB_BIT_NUM_OSC];
  assign gate_cell_two    = logic_cell_two_irq_flag_i
                          & enable_3_q[`PIEB_BIT_CELL_TWO];
  assign gate_cell_one    = logic_cell_one_irq_flag_i
                          & enable_3_q[`PIEB_BIT_CELL_ONE];

  assign pending = {gate_timer1_gate,
                    gate_converter,
                    gate_comp_one,
                    gate_num_osc,
                    gate_cell_two,
                    gate_cell_one,
                    gate_timer2,
                    gate_timer1_ovf};

  // Live enables beside the registered requests
  always @* begin
    core_view                       = `PIEB_REG_RESET;
    core_view[`PIEB_VIEW_GLOBAL_EN] = global_irq_enable_i;
    core_view[`PIEB_VIEW_PERIPH_EN] = periph_master_enable_i;
    core_view[`PIEB_VIEW_CREQ]      = creq_q;
    core_view[`PIEB_VIEW_PREQ]      = preq_q;
  end

  // ----------------------------------------
  // Enable registers
  // ----------------------------------------
  // Unimplemented bits are never stored, so they read zero
  always @* begin
    enable_1_d = enable_1_q;
    enable_2_d = enable_2_q;
    enable_3_d = enable_3_q;
    if (wr_en_1) begin
      enable_1_d = keep_impl(wbyte, `PIEB_IMPL_1);
    end
    if (wr_en_2) begin
      enable_2_d = keep_impl(wbyte, `PIEB_IMPL_2);
    end
    if (wr_en_3) begin
      enable_3_d = keep_impl(wbyte, `PIEB_IMPL_3);
    end
  end

  // ----------------------------------------
  // Request flags
  // ----------------------------------------
  // Event in the same cycle as a software clear wins
  always @* begin
    request_1_d = request_1_q;
    if (wr_req_1) begin
      request_1_d = keep_impl(wbyte, `PIEB_IMPL_1);
    end
    if (timer1_gate_evt_i) begin
      request_1_d[`PIEB_BIT_TIMER1_GATE] = 1'b1;
    end
    if (converter_evt_i) begin
      request_1_d[`PIEB_BIT_CONVERTER] = 1'b1;
    end
    if (timer2_match_evt_i) begin
      request_1_d[`PIEB_BIT_TIMER2] = 1'b1;
    end
    if (timer1_overflow_evt_i) begin
      request_1_d[`PIEB_BIT_TIMER1_OVF] = 1'b1;
    end
  end

  // ----------------------------------------
  // Request outputs
  // ----------------------------------------
  // Flags live regardless of enables, so software
  // must clear a stale flag before enabling it
  always @* begin
    preq_d = periph_master_enable_i & (|pending);
    creq_d = global_irq_enable_i & preq_d;
  end

  // ----------------------------------------
  // Block interrupt status and mask
  // ----------------------------------------
  // Rising edges only, so a held request sets once
  always @* begin
    event_set                  = `PIEB_REG_RESET;
    event_set[`PIEB_ST_PERIPH] = preq_d & ~preq_q;
    event_set[`PIEB_ST_CORE]   = creq_d & ~creq_q;
  end

  always @* begin
    status_d = status_q;
    mask_d   = mask_q;
    if (wr_status) begin
      status_d = status_q & ~wbyte;
    end
    // Set beats write-one-to-clear
    status_d = keep_impl(status_d | event_set, `PIEB_IMPL_STATUS);
    if (wr_mask) begin
      mask_d = keep_impl(wbyte, `PIEB_IMPL_STATUS);
    end
    irq_d = |(status_d & mask_d);
  end

  // ----------------------------------------
  // Bus answer
  // ----------------------------------------
  // One wait state: ack and data rise together
  always @* begin
    ack_d   = take;
    rdata_d = `PIEB_ZERO_WORD;
    if (rd_take) begin
      if (hit(adr_i, `PIEB_OFF_ENABLE_1)) begin
        rdata_d[7:0] = enable_1_q;
      end else if (hit(adr_i, `PIEB_OFF_ENABLE_2)) begin
        rdata_d[7:0] = enable_2_q;
      end else if (hit(adr_i, `PIEB_OFF_ENABLE_3)) begin
        rdata_d[7:0] = enable_3_q;
      end else if (hit(adr_i, `PIEB_OFF_REQUEST_1)) begin
        rdata_d[7:0] = request_1_q;
      end else if (hit(adr_i, `PIEB_OFF_IRQ_STATUS)) begin
        rdata_d[7:0] = status_q;
      end else if (hit(adr_i, `PIEB_OFF_IRQ_MASK)) begin
        rdata_d[7:0] = mask_q;
      end else if (hit(adr_i, `PIEB_OFF_PENDING)) begin
        rdata_d[7:0] = pending;
      end else if (hit(adr_i, `PIEB_OFF_CORE_VIEW)) begin
        rdata_d[7:0] = core_view;
      end
    end
  end

  // ----------------------------------------
  // Flip-flops
  // ----------------------------------------
  // Synchronous reset; every reset source clears the same way
  always @(posedge clk_i) begin
    if (rst_i) begin
      enable_1_q  <= `PIEB_REG_RESET;
      enable_2_q  <= `PIEB_REG_RESET;
      enable_3_q  <= `PIEB_REG_RESET;
      request_1_q <= `PIEB_REG_RESET;
      status_q    <= `PIEB_REG_RESET;
      mask_q      <= `PIEB_REG_RESET;
      ack_q       <= `PIEB_BIT_CLEAR;
      rdata_q     <= `PIEB_ZERO_WORD;
      preq_q      <= `PIEB_BIT_CLEAR;
      creq_q      <= `PIEB_BIT_CLEAR;
      irq_q       <= `PIEB_BIT_CLEAR;
    end else begin
      enable_1_q  <= enable_1_d;
      enable_2_q  <= enable_2_d;
      enable_3_q  <= enable_3_d;
      request_1_q <= request_1_d;
      status_q    <= status_d;
      mask_q      <= mask_d;
      ack_q       <= ack_d;
      rdata_q     <= rdata_d;
      preq_q      <= preq_d;
      creq_q      <= creq_d;
      irq_q       <= irq_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Every output straight from a flip-flop
  assign dat_o            = rdata_q;
  assign ack_o            = ack_q;
  assign periph_irq_req_o = preq_q;
  assign core_irq_req_o   = creq_q;
  assign irq_o            = irq_q;

endmodule

/* rtl/pieb_map.vh */
`ifndef PIEB_MAP_VH
`define PIEB_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PIEB_OFF_ENABLE_1    8'h00
`define PIEB_OFF_ENABLE_2    8'h04
`define PIEB_OFF_ENABLE_3    8'h08
`define PIEB_OFF_REQUEST_1   8'h0C
`define PIEB_OFF_IRQ_STATUS  8'h10
`define PIEB_OFF_IRQ_MASK    8'h14
`define PIEB_OFF_PENDING     8'h18
`define PIEB_OFF_CORE_VIEW   8'h1C

// ----------------------------------------
// Reset value and implemented-bit masks
// ----------------------------------------
`define PIEB_REG_RESET       8'h00
`define PIEB_IMPL_1          8'hC3
`define PIEB_IMPL_2          8'h24
`define PIEB_IMPL_3          8'h03
`define PIEB_IMPL_STATUS     8'h03
`define PIEB_ZERO_WORD       32'h0000_0000
`define PIEB_BIT_CLEAR       1'b0

// ----------------------------------------
// Bit positions, first enable/request pair
// ----------------------------------------
`define PIEB_BIT_TIMER1_GATE 7
`define PIEB_BIT_CONVERTER   6
`define PIEB_BIT_TIMER2      1
`define PIEB_BIT_TIMER1_OVF  0

// ----------------------------------------
// Bit positions, second and third enables
// ----------------------------------------
`define PIEB_BIT_COMP_ONE    5
`define PIEB_BIT_NUM_OSC     2
`define PIEB_BIT_CELL_TWO    1
`define PIEB_BIT_CELL_ONE    0

// ----------------------------------------
// Status and core view bits
// ----------------------------------------
`define PIEB_ST_PERIPH       0
`define PIEB_ST_CORE         1
`define PIEB_VIEW_GLOBAL_EN  7
`define PIEB_VIEW_PERIPH_EN  6
`define PIEB_VIEW_CREQ       1
`define PIEB_VIEW_PREQ       0

`endif
